// ===== hw/addr_gen_defines.vh
// Constants shared by the address generation block and its table fetcher
`ifndef ADDR_GEN_DEFINES_VH
`define ADDR_GEN_DEFINES_VH

// Command codes from the sequencer
`define OP_SEQ 4'h0
`define OP_REL 4'h1
`define OP_ABS 4'h2
`define OP_TBL 4'h3
`define OP_REGBR 4'h4
`define OP_DIRECT 4'h5
`define OP_SHORT 4'h6
`define OP_SHORT_WORD 4'h7
`define OP_SFR 4'h8
`define OP_REG 4'h9
`define OP_IND_DE 4'hA
`define OP_IND_HL 4'hB
`define OP_BASED 4'hC
`define OP_PUSH 4'hD
`define OP_POP 4'hE

// Memory map
`define CALL_TABLE_BASE 16'h0040
`define CALL_TABLE_LAST 16'h007F
`define SHORT_WIN_LO 16'hFE20
`define SHORT_WIN_HI 16'hFF1F
`define HS_RAM_LO 16'hFE20
`define HS_RAM_HI 16'hFEFF
`define SFR_LO 16'hFF00
`define SFR_GAP_LO 16'hFFD0
`define SFR_GAP_HI 16'hFFDF
`define SFR_PAGE 8'hFF
`define SHORT_TOP_BITS 7'h7F
`define SHORT_SFR_LIMIT 8'h20
`define DISP_SIGN_BIT 7

// Reset values
`define PC_RESET 16'h0000

`endif

// ===== hw/call_table_fetch.v
// Two-byte fetch of a call-table destination address
`timescale 1ns/1ps
`include "addr_gen_defines.vh"

module call_table_fetch (
  input wire clk,
  input wire srst,
  input wire start,
  input wire [4:0] call_table_index,
  input wire [7:0] mem_rd_data,
  input wire mem_rd_ack,
  output reg mem_rd_req,
  output reg [15:0] mem_rd_addr,
  output reg done,
  output reg [15:0] target
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOW = 2'b01;
  localparam [1:0] ST_HIGH = 2'b10;

  reg [1:0] state_reg;
  reg [7:0] low_byte_reg;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      low_byte_reg <= 8'h00;
      mem_rd_req <= 1'b0;
      mem_rd_addr <= 16'h0000;
      done <= 1'b0;
      target <= 16'h0000;
    end else begin
      done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            // Entry sits at base plus twice the index, low byte first
            mem_rd_addr <= `CALL_TABLE_BASE +
              {10'h000, call_table_index, 1'b0};
            mem_rd_req <= 1'b1;
            state_reg <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (mem_rd_ack) begin
            low_byte_reg <= mem_rd_data;
            mem_rd_addr <= mem_rd_addr + 16'h0001;
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (mem_rd_ack) begin
            target <= {mem_rd_data, low_byte_reg};
            mem_rd_req <= 1'b0;
            done <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          mem_rd_req <= 1'b0;
        end
      endcase
    end
  end

endmodule // call_table_fetch

// ===== hw/cpu_address_generation.v
// Program counter and operand address generation for the CPU core
// Function
// - Sequential fetch advances counter per instruction byte
// - Relative target is next instruction plus displacement
// - Displacement signed, bit 7 sign-extends upward
// - Relative form for short and conditional branches
// - Absolute call/branch loads 16-bit immediate
// - Table call index from opcode bits 1-5
// - Call table lives at 40H through 7FH
// - Register branch loads accumulator pair
// - Direct operand uses 16-bit immediate unchanged
// - Short direct reaches FE20H to FF1FH window
// - Window splits RAM FE20H-FEFFH, registers FF00H-FF1FH
// - Address bit 8 set only for 00H-1FH
// - Special registers FF00H-FFCFH and FFE0H-FFFFH
// - Register code selects byte register or pair
// - Indirect uses either pointer pair contents
// - Based adds zero-extended offset to base pair
// - Based sum carry discarded, wraps 16 bits
// - Stack operations address through stack pointer
`timescale 1ns/1ps
`include "addr_gen_defines.vh"

module cpu_address_generation #(
  parameter [15:0] PC_RESET_VALUE = `PC_RESET
) (
  input wire clk,
  input wire srst,
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [7:0] opcode,
  input wire [2:0] instr_len,
  input wire [7:0] imm8,
  input wire [15:0] absolute_address_operand,
  input wire [15:0] accumulator_pair,
  input wire [15:0] second_pointer_pair,
  input wire [15:0] base_pointer_pair,
  input wire [15:0] stack_pointer,
  input wire [7:0] mem_rd_data,
  input wire mem_rd_ack,
  output wire busy,
  output wire op_done,
  output wire [15:0] program_counter,
  output wire pc_update,
  output wire [15:0] operand_addr,
  output wire operand_valid,
  output wire operand_is_sfr,
  output wire operand_fault,
  output wire [2:0] reg_byte_sel,
  output wire [1:0] word_reg_operand,
  output wire reg_is_word,
  output wire reg_valid,
  output wire [15:0] stack_pointer_next,
  output wire stack_valid,
  output wire stack_fault,
  output wire mem_rd_req,
  output wire [15:0] mem_rd_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Plain 16-bit sum; any carry out falls away
  function [15:0] add16;
    input [15:0] a;
    input [15:0] b;
    begin
      add16 = a + b;
    end
  endfunction

  function [15:0] short_addr;
    input [7:0] field;
    reg bit8;
    begin
      bit8 = (field < `SHORT_SFR_LIMIT);
      short_addr = {`SHORT_TOP_BITS, bit8, field};
    end
  endfunction

  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [15:0] pc_reg;
  reg [15:0] pc_next;
  reg pc_update_reg;
  reg busy_reg;
  reg op_done_reg;
  reg [15:0] operand_addr_reg;
  reg [15:0] operand_addr_next;
  reg operand_valid_reg;
  reg operand_valid_next;
  reg operand_is_sfr_reg;
  reg operand_is_sfr_next;
  reg operand_fault_reg;
  reg operand_fault_next;
  reg [2:0] reg_byte_sel_reg;
  reg [1:0] word_reg_operand_reg;
  reg reg_is_word_reg;
  reg reg_valid_reg;
  reg [15:0] sp_next_reg;
  reg [15:0] sp_next;
  reg [15:0] stack_addr;
  reg stack_valid_reg;
  reg stack_fault_reg;
  reg pc_load;
  reg reg_op;
  reg stack_op;

  wire accept;
  wire tbl_start;
  wire tbl_done;
  wire [15:0] tbl_target;
  wire [15:0] next_instr;
  wire [15:0] disp_ext;

  // A busy table fetch refuses new commands until it completes
  assign accept = cmd_valid && !busy_reg;
  assign tbl_start = accept && (cmd_op == `OP_TBL);

  assign next_instr = add16(pc_reg, {13'h0000, instr_len});
  assign disp_ext = {{8{imm8[`DISP_SIGN_BIT]}}, imm8};

  ////////////////////////////////////////////////////////////////////////////
  // Table fetcher

  call_table_fetch u_fetch (
    .clk(clk),
    .srst(srst),
    .start(tbl_start),
    .call_table_index(opcode[5:1]),
    .mem_rd_data(mem_rd_data),
    .mem_rd_ack(mem_rd_ack),
    .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr),
    .done(tbl_done),
    .target(tbl_target)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-value decode

  always @* begin
    pc_next = pc_reg;
    pc_load = 1'b0;
    operand_addr_next = operand_addr_reg;
    operand_valid_next = 1'b0;
    operand_is_sfr_next = operand_is_sfr_reg;
    operand_fault_next = operand_fault_reg;
    reg_op = 1'b0;
    stack_op = 1'b0;
    stack_addr = stack_pointer;
    sp_next = stack_pointer;
    if (tbl_done) begin
      pc_next = tbl_target;
      pc_load = 1'b1;
    end else if (accept) begin
      case (cmd_op)
        `OP_SEQ: begin
          pc_next = next_instr;
          pc_load = 1'b1;
        end
        `OP_REL: begin
          // Used for short branch and all conditional branches
          pc_next = add16(next_instr, disp_ext);
          pc_load = 1'b1;
        end
        `OP_ABS: begin
          pc_next = absolute_address_operand;
          pc_load = 1'b1;
        end
        `OP_REGBR: begin
          pc_next = accumulator_pair;
          pc_load = 1'b1;
        end
        `OP_DIRECT: begin
          operand_addr_next = absolute_address_operand;
          operand_valid_next = 1'b1;
          operand_is_sfr_next = (absolute_address_operand >= `SFR_LO);
          operand_fault_next = 1'b0;
        end
        `OP_SHORT, `OP_SHORT_WORD: begin
          operand_addr_next = short_addr(imm8);
          operand_valid_next = 1'b1;
          operand_is_sfr_next = (imm8 < `SHORT_SFR_LIMIT);
          // Odd word address is a sequencer error; flagged, not fixed
          operand_fault_next = (cmd_op == `OP_SHORT_WORD) &&
            imm8[0];
        end
        `OP_SFR: begin
          operand_addr_next = {`SFR_PAGE, imm8};
          operand_valid_next = 1'b1;
          operand_is_sfr_next = 1'b1;
          operand_fault_next = in_range({`SFR_PAGE, imm8},
            `SFR_GAP_LO, `SFR_GAP_HI);
        end
        `OP_REG: begin
          reg_op = 1'b1;
        end
        `OP_IND_DE: begin
          operand_addr_next = second_pointer_pair;
          operand_valid_next = 1'b1;
          operand_is_sfr_next = (second_pointer_pair >= `SFR_LO);
          operand_fault_next = 1'b0;
        end
        `OP_IND_HL: begin
          operand_addr_next = base_pointer_pair;
          operand_valid_next = 1'b1;
          operand_is_sfr_next = (base_pointer_pair >= `SFR_LO);
          operand_fault_next = 1'b0;
        end
        `OP_BASED: begin
          operand_addr_next = add16(base_pointer_pair,
            {8'h00, imm8});
          operand_valid_next = 1'b1;
          operand_is_sfr_next = (operand_addr_next >= `SFR_LO);
          operand_fault_next = 1'b0;
        end
        `OP_PUSH: begin
          // Pre-decrement: byte goes below the current top
          stack_op = 1'b1;
          sp_next = add16(stack_pointer, 16'hFFFF);
          stack_addr = sp_next;
        end
        `OP_POP: begin
          stack_op = 1'b1;
          stack_addr = stack_pointer;
          sp_next = add16(stack_pointer, 16'h0001);
        end
        default: begin
          pc_load = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always @(posedge clk) begin
    if (srst) begin
      pc_reg <= PC_RESET_VALUE;
      pc_update_reg <= 1'b0;
      busy_reg <= 1'b0;
      op_done_reg <= 1'b0;
      operand_addr_reg <= 16'h0000;
      operand_valid_reg <= 1'b0;
      operand_is_sfr_reg <= 1'b0;
      operand_fault_reg <= 1'b0;
      reg_byte_sel_reg <= 3'h0;
      word_reg_operand_reg <= 2'h0;
      reg_is_word_reg <= 1'b0;
      reg_valid_reg <= 1'b0;
      sp_next_reg <= 16'h0000;
      stack_valid_reg <= 1'b0;
      stack_fault_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      pc_update_reg <= pc_load;
      operand_addr_reg <= operand_addr_next;
      operand_valid_reg <= operand_valid_next;
      operand_is_sfr_reg <= operand_is_sfr_next;
      operand_fault_reg <= operand_fault_next;
      reg_valid_reg <= reg_op;
      if (reg_op) begin
        reg_byte_sel_reg <= opcode[2:0];
        word_reg_operand_reg <= opcode[2:1];
        reg_is_word_reg <= opcode[3];
      end
      stack_valid_reg <= stack_op;
      if (stack_op) begin
        sp_next_reg <= sp_next;
        // Stack cannot reach beyond high-speed RAM; report escapes
        stack_fault_reg <= !in_range(stack_addr,
          `HS_RAM_LO, `HS_RAM_HI);
        operand_addr_reg <= stack_addr;
        operand_is_sfr_reg <= 1'b0;
        operand_fault_reg <= 1'b0;
      end
      if (tbl_start) begin
        busy_reg <= 1'b1;
      end else if (tbl_done) begin
        busy_reg <= 1'b0;
      end
      op_done_reg <= (accept && (cmd_op != `OP_TBL)) || tbl_done;
    end
  end

  assign busy = busy_reg;
  assign op_done = op_done_reg;
  assign program_counter = pc_reg;
  assign pc_update = pc_update_reg;
  assign operand_addr = operand_addr_reg;
  assign operand_valid = operand_valid_reg;
  assign operand_is_sfr = operand_is_sfr_reg;
  assign operand_fault = operand_fault_reg;
  assign reg_byte_sel = reg_byte_sel_reg;
  assign word_reg_operand = word_reg_operand_reg;
  assign reg_is_word = reg_is_word_reg;
  assign reg_valid = reg_valid_reg;
  assign stack_pointer_next = sp_next_reg;
  assign stack_valid = stack_valid_reg;
  assign stack_fault = stack_fault_reg;

endmodule // cpu_address_generation

// ===== verif/table_mem_model.sv
// Byte memory that answers the call-table reads
`timescale 1ns/1ps
module table_mem_model (
  input wire clk,
  input wire [3:0] lat,
  input wire mem_rd_req,
  input wire [15:0] mem_rd_addr,
  output wire mem_rd_ack,
  output wire [7:0] mem_rd_data
);
  reg [3:0] cnt = 4'h0;
  reg [7:0] last = 8'h00;
  // Wait states come from the bench; zero acks in the request cycle
  assign mem_rd_ack = mem_rd_req && cnt >= lat;
  // Bytes scrambled by address; idle data is the inverse of the last byte
  assign mem_rd_data = mem_rd_ack ? mem_rd_addr[7:0] ^ 8'hA5 : ~last;
  always @(posedge clk) begin
    if (mem_rd_ack) begin
      cnt <= 4'h0;
      last <= mem_rd_data;
    end else if (mem_rd_req) begin
      cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
    end
  end
endmodule // table_mem_model

// ===== verif/cpu_address_generation_sva.sv
// Assertions on the address generation ports
`timescale 1ns/1ps
`include "addr_gen_defines.vh"
module cpu_address_generation_sva (
  input wire clk,
  input wire srst,
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [7:0] opcode,
  input wire [2:0] instr_len,
  input wire [7:0] imm8,
  input wire [15:0] absolute_address_operand,
  input wire [15:0] accumulator_pair,
  input wire [15:0] second_pointer_pair,
  input wire [15:0] base_pointer_pair,
  input wire mem_rd_ack,
  input wire busy,
  input wire [15:0] program_counter,
  input wire [15:0] operand_addr,
  input wire operand_valid,
  input wire mem_rd_req,
  input wire [15:0] mem_rd_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire go = cmd_valid && !busy;
  wire [15:0] rel_sum = program_counter + {13'h0000, instr_len}
    + {{8{imm8[7]}}, imm8};
  wire [15:0] tbl_lo = 16'h0040 + {10'h000, opcode[5:1], 1'b0};
  ////////////////////////////////////////////////////////////////////
  chk_seq_step: assert property (
    go && cmd_op == `OP_SEQ |=> program_counter ==
    $past(program_counter) + {13'h0000, $past(instr_len)}) else $error("seq");
  chk_rel_target: assert property (
    go && cmd_op == `OP_REL |=> program_counter == $past(rel_sum))
    else $error("rel");
  chk_abs_load: assert property (
    go && cmd_op == `OP_ABS |=> program_counter ==
    $past(absolute_address_operand)) else $error("abs");
  chk_regbr_load: assert property (
    go && cmd_op == `OP_REGBR |=> program_counter == $past(accumulator_pair))
    else $error("regbr");
  chk_short_form: assert property (
    go && cmd_op == `OP_SHORT |=> operand_valid && operand_addr ==
    {7'h7F, $past(imm8) < 8'h20, $past(imm8)}) else $error("short");
  chk_ind_de: assert property (
    go && cmd_op == `OP_IND_DE |=> operand_addr == $past(second_pointer_pair))
    else $error("ind");
  chk_based_wrap: assert property (
    go && cmd_op == `OP_BASED |=> operand_addr ==
    $past(base_pointer_pair) + {8'h00, $past(imm8)}) else $error("based");
  chk_tbl_first: assert property (
    go && cmd_op == `OP_TBL |=> busy && mem_rd_req &&
    mem_rd_addr == $past(tbl_lo)) else $error("tbl start");
  chk_tbl_pair: assert property (
    mem_rd_req && mem_rd_ack && !mem_rd_addr[0] |=> mem_rd_req &&
    mem_rd_addr == $past(mem_rd_addr) + 16'h0001) else $error("tbl pair");
  chk_req_hold: assert property (
    mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("hold");
endmodule // cpu_address_generation_sva
bind cpu_address_generation cpu_address_generation_sva chk (.clk, .srst,
  .cmd_valid, .cmd_op, .opcode, .instr_len, .imm8, .absolute_address_operand,
  .accumulator_pair, .second_pointer_pair, .base_pointer_pair, .mem_rd_ack,
  .busy, .program_counter, .operand_addr, .operand_valid, .mem_rd_req,
  .mem_rd_addr);

// ===== verif/tb_cpu_address_generation.sv
// Table-driven bench for the address generation block
`timescale 1ns/1ps
`include "addr_gen_defines.vh"
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t %h vs %h", $time, a, b); end end
module tb_cpu_address_generation;
  typedef struct {logic [3:0] op; logic [7:0] opc, imm; logic [2:0] len;
    logic [1:0] sel; logic [15:0] exp;} row_t;
  logic clk = 0, srst = 1, cmd_valid = 0, busy, op_done, pc_update;
  logic operand_valid, reg_is_word, reg_valid, stack_valid;
  logic operand_is_sfr, operand_fault, stack_fault;
  logic [15:0] sp = 16'hFE80;
  logic mem_rd_req, mem_rd_ack;
  logic [3:0] cmd_op = 0, lat = 0;
  logic [7:0] opcode = 0, imm8 = 0, mem_rd_data;
  logic [2:0] instr_len = 0, reg_byte_sel;
  logic [1:0] word_reg_operand;
  logic [15:0] program_counter, operand_addr, stack_pointer_next, mem_rd_addr;
  logic [15:0] obs;
  row_t rows[$];
  int fails = 0, total_checks = 0, i;
  cpu_address_generation dut (.clk, .srst, .cmd_valid, .cmd_op, .opcode,
    .instr_len, .imm8, .absolute_address_operand(16'hABCD),
    .accumulator_pair(16'h1234), .second_pointer_pair(16'h5678),
    .base_pointer_pair(16'hFFF0), .stack_pointer(sp), .mem_rd_data,
    .mem_rd_ack, .busy, .op_done, .program_counter, .pc_update, .operand_addr,
    .operand_valid, .operand_is_sfr, .operand_fault, .reg_byte_sel,
    .word_reg_operand, .reg_is_word, .reg_valid, .stack_pointer_next,
    .stack_valid, .stack_fault, .mem_rd_req, .mem_rd_addr);
  table_mem_model mem (.clk, .lat, .mem_rd_req, .mem_rd_addr, .mem_rd_ack,
    .mem_rd_data);
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  // Leaves cmd_valid high so rows run back to back
  task cmd(input [3:0] op, input [7:0] opc, imm, input [2:0] len);
    cmd_op = op;
    opcode = opc;
    imm8 = imm;
    instr_len = len;
    cmd_valid = 1;
    @(posedge clk) #1;
  endtask
  task r(input [3:0] op, input [7:0] opc, imm, input [2:0] len,
    input [1:0] sel, input [15:0] exp);
    rows.push_back('{op, opc, imm, len, sel, exp});
  endtask
  // Second command rides the busy window and must be dropped
  task tbl(input [4:0] idx, input [15:0] exp);
    cmd(`OP_TBL, {2'b00, idx, 1'b0}, 8'h00, 3'h1);
    cmd(`OP_ABS, 8'h00, 8'h00, 3'h3);
    cmd_valid = 0;
    i = 0;
    while (op_done !== 1'b1 && i < 30) begin
      @(posedge clk) #1 i++;
    end
    `CK(pc_update, 1'b1)
    `CK(op_done, 1'b1)
    `CK(program_counter, exp)
  endtask
  task stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    r(`OP_ABS, 0, 0, 3, 0, 16'hABCD);
    r(`OP_SEQ, 0, 0, 3, 0, 16'hABD0);
    r(`OP_REL, 0, 8'h80, 2, 0, 16'hAB52);
    r(`OP_REL, 0, 8'h7F, 2, 0, 16'hABD3);
    r(`OP_REGBR, 0, 0, 1, 0, 16'h1234);
    r(`OP_DIRECT, 0, 0, 3, 1, 16'hABCD);
    r(`OP_SHORT, 0, 8'h20, 2, 1, 16'hFE20);
    r(`OP_SHORT, 0, 8'hFF, 2, 1, 16'hFEFF);
    r(`OP_SHORT, 0, 8'h00, 2, 1, 16'hFF00);
    r(`OP_SHORT, 0, 8'h1F, 2, 1, 16'hFF1F);
    r(`OP_SHORT_WORD, 0, 8'h40, 2, 1, 16'hFE40);
    r(`OP_SFR, 0, 8'hE0, 2, 1, 16'hFFE0);
    r(`OP_SFR, 0, 8'hCF, 2, 1, 16'hFFCF);
    r(`OP_IND_DE, 0, 0, 1, 1, 16'h5678);
    r(`OP_IND_HL, 0, 0, 1, 1, 16'hFFF0);
    r(`OP_BASED, 0, 8'h10, 2, 1, 16'h0000);
    r(`OP_BASED, 0, 8'hFF, 2, 1, 16'h00EF);
    r(`OP_PUSH, 0, 0, 1, 1, 16'hFE7F);
    r(`OP_PUSH, 0, 0, 1, 3, 16'hFE7F);
    r(`OP_POP, 0, 0, 1, 1, 16'hFE80);
    r(`OP_POP, 0, 0, 1, 3, 16'hFE81);
    r(`OP_REG, 8'h0D, 0, 1, 2, 16'h0035);
    repeat (3) @(posedge clk);
    #1 srst = 0;
    `CK(program_counter, 16'h0000)
    `CK(busy, 1'b0)
    foreach (rows[k]) begin
      cmd(rows[k].op, rows[k].opc, rows[k].imm, rows[k].len);
      case (rows[k].sel)
        0: obs = program_counter;
        1: obs = operand_addr;
        2: obs = {10'h000, reg_is_word, word_reg_operand, reg_byte_sel};
        default: obs = stack_pointer_next;
      endcase
      `CK(obs, rows[k].exp)
      `CK(pc_update | operand_valid | reg_valid | stack_valid, 1'b1)
    end
    // Flags: register area, odd word field, register gap, stack escape
    cmd(`OP_SHORT, 8'h00, 8'h10, 3'h2);
    `CK(operand_is_sfr, 1'b1)
    `CK(operand_fault, 1'b0)
    cmd(`OP_SHORT_WORD, 8'h00, 8'h41, 3'h2);
    `CK(operand_fault, 1'b1)
    `CK(operand_is_sfr, 1'b0)
    cmd(`OP_SFR, 8'h00, 8'hD5, 3'h2);
    `CK(operand_fault, 1'b1)
    `CK(operand_addr, 16'hFFD5)
    cmd(`OP_DIRECT, 8'h00, 8'h00, 3'h3);
    `CK(operand_is_sfr, 1'b0)
    `CK(operand_fault, 1'b0)
    cmd(`OP_PUSH, 8'h00, 8'h00, 3'h1);
    `CK(stack_fault, 1'b0)
    `CK(op_done, 1'b1)
    sp = 16'hFE20;
    cmd(`OP_PUSH, 8'h00, 8'h00, 3'h1);
    `CK(operand_addr, 16'hFE1F)
    `CK(stack_fault, 1'b1)
    tbl(5'd31, 16'hDADB);
    lat = 3;
    tbl(5'd0, 16'hE4E5);
    // Reset in the middle of a slow table fetch
    lat = 5;
    cmd(`OP_TBL, 8'h02, 8'h00, 3'h1);
    cmd_valid = 0;
    srst = 1;
    @(posedge clk) #1 srst = 0;
    `CK(busy, 1'b0)
    `CK(mem_rd_req, 1'b0)
    `CK(program_counter, 16'h0000)
    stop_test;
  end
endmodule // tb_cpu_address_generation
